// *** shared/csacal_pkg.sv ***
package csacal_pkg;
	localparam int NAMP = 3;
	localparam int TRIM_W = 6;
	localparam int CODE_AW = 2;
	localparam int ADDR_W = 6;
	// Amplifier gain codes: 5, 10, 20 and 40 V/V
	localparam logic [1:0] GAIN_5 = 2'h0;
	localparam logic [1:0] GAIN_10 = 2'h1;
	localparam logic [1:0] GAIN_20 = 2'h2;
	localparam logic [1:0] GAIN_40 = 2'h3;
	localparam logic [1:0] GAIN_RST = GAIN_5;
	localparam int CLK_PERIOD_NS = 4;
	localparam int AUTO_TIME_US = 50;
	// Longest time, so the cycle count rounds down
	localparam int AUTO_MAX_CYC = AUTO_TIME_US * 1000 / CLK_PERIOD_NS;
	localparam int STEP_CYC = 1024;
	localparam logic [ADDR_W-1:0] OFS_CTRL = 6'h00;
	localparam logic [ADDR_W-1:0] OFS_STAT = 6'h04;
	localparam logic [ADDR_W-1:0] OFS_REQ = 6'h08;
	localparam logic [ADDR_W-1:0] OFS_CODE = 6'h10;
	localparam int CTRL_GAIN_LSB = 0;
	localparam int CTRL_UNIDIR = 2;
	localparam int CTRL_METHOD = 3;
	localparam int CTRL_RTAUTO = 4;
	localparam int STAT_CAL_LSB = 0;
	localparam int STAT_BUSY = 3;
	localparam int STAT_PWR = 4;
	localparam int STAT_PEND = 5;
	// Midscale trim code used until a trim has run
	localparam logic [TRIM_W-1:0] CODE_RST = 6'h20;
	typedef enum logic [1:0] {
		CSACAL_IDLE = 2'h0,
		CSACAL_RUN = 2'h1,
		CSACAL_DONE = 2'h3
	} csacal_state_e;
endpackage

// *** design/csacal_trim_mem.sv ***
`timescale 1ns/100ps
module csacal_trim_mem
#(
	parameter int P_DEPTH = csacal_pkg::NAMP,
	parameter int P_W = csacal_pkg::TRIM_W,
	parameter int P_AW = csacal_pkg::CODE_AW
)
(
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic [P_DEPTH-1:0] i_we,
	input wire logic [P_DEPTH*P_W-1:0] i_wdata,
	input wire logic [P_AW-1:0] i_raddr,
	output logic [P_W-1:0] o_rdata
);
	import csacal_pkg::*;
	logic [P_W-1:0] mem_q [P_DEPTH];

	if (P_DEPTH > (1 << P_AW))
	begin : g_bad_depth
		$error("Trim memory depth exceeds its address range");
	end

	always_ff @(posedge i_clk)
	begin
		for (int i = 0; i < P_DEPTH; i++)
		begin
			if (!i_resetn)
				mem_q[i] <= P_W'(CODE_RST);
			else if (i_we[i])
				mem_q[i] <= i_wdata[i*P_W +: P_W];
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_resetn)
			o_rdata <= P_W'(CODE_RST);
		else if (int'(i_raddr) < P_DEPTH)
			o_rdata <= mem_q[i_raddr];
		else
			o_rdata <= '0;
	end
endmodule

// *** design/csacal_autotrim.sv ***
`timescale 1ns/100ps
module csacal_autotrim
#(
	parameter int P_NAMP = csacal_pkg::NAMP,
	parameter int P_W = csacal_pkg::TRIM_W,
	parameter int P_STEP = csacal_pkg::STEP_CYC
)
(
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic i_start,
	input wire logic [P_NAMP-1:0] i_mask,
	input wire logic [P_NAMP-1:0] i_cmp,
	output logic o_busy,
	output logic o_done,
	output logic [P_NAMP*P_W-1:0] o_code
);
	import csacal_pkg::*;
	localparam int DIV_W = $clog2(P_STEP + 1);
	localparam int BIT_W = $clog2(P_W + 1);
	csacal_state_e state_q;
	logic [P_NAMP-1:0] mask_q;
	logic [DIV_W-1:0] div_q;
	logic [BIT_W-1:0] bit_q;
	logic step_en;

	// A zero-length step would leave the divider with no bits
	if (P_STEP < 1 || P_NAMP < 1 || P_W < 1)
	begin : g_bad_param
		$error("Trim engine needs a step, an amplifier and a code bit");
	end

	// One successive-approximation step per divider pulse
	assign step_en = (state_q == CSACAL_RUN) && (div_q == DIV_W'(P_STEP - 1));
	assign o_busy = (state_q != CSACAL_IDLE);
	assign o_done = (state_q == CSACAL_DONE);

	always_ff @(posedge i_clk)
	begin
		if (!i_resetn)
			state_q <= CSACAL_IDLE;
		else
		begin
			case (state_q)
				CSACAL_IDLE:
					if (i_start)
						state_q <= CSACAL_RUN;
				CSACAL_RUN:
					if (step_en && bit_q == '0)
						state_q <= CSACAL_DONE;
				default:
					state_q <= CSACAL_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_resetn || state_q != CSACAL_RUN || step_en)
			div_q <= '0;
		else
			div_q <= div_q + 1'b1;
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_resetn)
		begin
			mask_q <= '0;
			bit_q <= '0;
			o_code <= '0;
		end
		else if (state_q == CSACAL_IDLE && i_start)
		begin
			mask_q <= i_mask;
			bit_q <= BIT_W'(P_W - 1);
			for (int i = 0; i < P_NAMP; i++)
				if (i_mask[i])
					o_code[i*P_W +: P_W] <= P_W'(1) << (P_W - 1);
		end
		else if (step_en)
		begin
			// Comparator high means the residual offset still wants more trim
			for (int i = 0; i < P_NAMP; i++)
			begin
				if (mask_q[i])
				begin
					o_code[i*P_W + int'(bit_q)] <= i_cmp[i];
					if (bit_q != '0)
						o_code[i*P_W + int'(bit_q) - 1] <= 1'b1;
				end
			end
			if (bit_q != '0)
				bit_q <= bit_q - 1'b1;
		end
	end
endmodule

// *** design/csacal_top.sv ***
`timescale 1ns/100ps
module csacal_top
#(
	parameter bit P_PIN_VARIANT = 1'b0,
	parameter int P_AUTO_MAX_CYC = csacal_pkg::AUTO_MAX_CYC,
	parameter int P_STEP_CYC = csacal_pkg::STEP_CYC
)
(
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic [csacal_pkg::ADDR_W-1:0] i_address,
	input wire logic i_read,
	input wire logic i_write,
	input wire logic [31:0] i_writedata,
	input wire logic [3:0] i_byteenable,
	output logic [31:0] o_readdata,
	output logic o_waitrequest,
	input wire logic i_vref_ok,
	input wire logic i_trim_pin,
	input wire logic [csacal_pkg::NAMP-1:0] i_amp_cmp,
	output logic [1:0] o_amp_gain,
	output logic o_ref_div_bypass,
	output logic [csacal_pkg::NAMP-1:0] o_amp_cal,
	output logic [csacal_pkg::NAMP*csacal_pkg::TRIM_W-1:0] o_amp_trim_code,
	output logic o_autotrim_busy
);
	import csacal_pkg::*;
	localparam int BUS_MAX = 2;
	localparam int SETTLE_MAX = 2;
	localparam logic [NAMP-1:0] ALL_AMPS = {NAMP{1'b1}};

	if (P_STEP_CYC * TRIM_W + 4 > P_AUTO_MAX_CYC || P_STEP_CYC < 1)
	begin : g_bad_timing
		$error("Trim steps cannot finish inside the trim time");
	end

	logic [1:0] gain_q;
	logic unidir_q;
	logic method_q;
	logic rtauto_q;
	logic [NAMP-1:0] req_q;
	logic [NAMP-1:0] pend_q;
	logic [NAMP-1:0] run_mask_q;
	logic [TRIM_W-1:0] code_q [NAMP];
	logic vref_prev_q;
	logic pin_prev_q;
	logic pwr_done_q;
	logic wait_q;
	logic acc_q;
	logic [15:0] run_cnt_q;
	logic bus_wr;
	logic req_wr;
	logic [NAMP-1:0] req_new;
	logic [NAMP-1:0] trig;
	logic pin_manual;
	logic eng_start;
	logic eng_busy;
	logic eng_done;
	logic [NAMP*TRIM_W-1:0] eng_code;
	logic [TRIM_W-1:0] mem_rdata;

	function automatic logic is_code_addr(input logic [ADDR_W-1:0] a);
		return (a >= OFS_CODE) && (a < OFS_CODE + ADDR_W'(4 * NAMP));
	endfunction

	function automatic logic [31:0] read_mux(input logic [ADDR_W-1:0] a,
		input logic [31:0] ctrl, input logic [31:0] stat,
		input logic [31:0] req, input logic [TRIM_W-1:0] code);
		logic [31:0] r;
		r = 32'h0000_0000;
		if (a == OFS_CTRL)
			r = ctrl;
		else if (a == OFS_STAT)
			r = stat;
		else if (a == OFS_REQ)
			r = req;
		else if (is_code_addr(a))
			r = 32'(code);
		return r;
	endfunction

	// Avalon slave: waitrequest drops two cycles after a request appears
	always_ff @(posedge i_clk)
	begin
		if (!i_resetn)
		begin
			wait_q <= 1'b1;
			acc_q <= 1'b0;
		end
		else if (!wait_q)
		begin
			wait_q <= 1'b1;
			acc_q <= 1'b0;
		end
		else if (i_read || i_write)
		begin
			acc_q <= 1'b1;
			if (acc_q)
				wait_q <= 1'b0;
		end
	end
	assign o_waitrequest = wait_q;
	assign bus_wr = i_write && !wait_q && i_byteenable[0];
	assign req_wr = bus_wr && (i_address == OFS_REQ) && !P_PIN_VARIANT;
	assign req_new = i_writedata[NAMP-1:0] & ~req_q;

	always_ff @(posedge i_clk)
	begin
		if (!i_resetn)
			o_readdata <= 32'h0000_0000;
		else if (i_read && wait_q && acc_q)
			o_readdata <= read_mux(i_address,
				32'({rtauto_q, method_q, unidir_q, gain_q}),
				32'({pend_q != '0, pwr_done_q, eng_busy, o_amp_cal}),
				32'(req_q), mem_rdata);
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_resetn)
		begin
			gain_q <= GAIN_RST;
			unidir_q <= 1'b0;
			method_q <= 1'b0;
			rtauto_q <= 1'b0;
		end
		else if (bus_wr && i_address == OFS_CTRL)
		begin
			gain_q <= i_writedata[CTRL_GAIN_LSB +: 2];
			unidir_q <= i_writedata[CTRL_UNIDIR];
			method_q <= i_writedata[CTRL_METHOD];
			rtauto_q <= i_writedata[CTRL_RTAUTO];
		end
	end

	// no request bits on pin variant
	always_ff @(posedge i_clk)
	begin
		if (!i_resetn || P_PIN_VARIANT)
			req_q <= '0;
		else if (req_wr)
			req_q <= i_writedata[NAMP-1:0];
		else if (eng_done && method_q)
			req_q <= req_q & ~run_mask_q;
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_resetn)
		begin
			vref_prev_q <= 1'b0;
			pin_prev_q <= 1'b0;
			pwr_done_q <= 1'b0;
		end
		else
		begin
			vref_prev_q <= i_vref_ok;
			pin_prev_q <= i_trim_pin;
			if (i_vref_ok && !vref_prev_q)
				pwr_done_q <= 1'b1;
		end
	end

	always_comb
	begin
		trig = '0;
		if (i_vref_ok && !vref_prev_q && !pwr_done_q)
			trig = ALL_AMPS;
		if (req_wr && method_q && rtauto_q)
			trig = trig | req_new;
		if (i_trim_pin && !pin_prev_q && method_q && !P_PIN_VARIANT)
			trig = ALL_AMPS;
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_resetn)
			pend_q <= '0;
		else if (eng_start)
			pend_q <= trig;
		else
			pend_q <= pend_q | trig;
	end
	assign eng_start = !eng_busy && (pend_q != '0);

	always_ff @(posedge i_clk)
	begin
		if (!i_resetn)
			run_mask_q <= '0;
		else if (eng_start)
			run_mask_q <= pend_q;
	end

	csacal_autotrim #(
		.P_NAMP(NAMP),
		.P_W(TRIM_W),
		.P_STEP(P_STEP_CYC)
	) u_autotrim (
		.i_clk(i_clk),
		.i_resetn(i_resetn),
		.i_start(eng_start),
		.i_mask(pend_q),
		.i_cmp(i_amp_cmp),
		.o_busy(eng_busy),
		.o_done(eng_done),
		.o_code(eng_code)
	);

	always_ff @(posedge i_clk)
	begin
		for (int i = 0; i < NAMP; i++)
		begin
			if (!i_resetn)
				code_q[i] <= CODE_RST;
			else if (eng_done && run_mask_q[i])
				code_q[i] <= eng_code[i*TRIM_W +: TRIM_W];
		end
	end

	csacal_trim_mem #(
		.P_DEPTH(NAMP),
		.P_W(TRIM_W),
		.P_AW(CODE_AW)
	) u_trim_mem (
		.i_clk(i_clk),
		.i_resetn(i_resetn),
		.i_we(eng_done ? run_mask_q : '0),
		.i_wdata(eng_code),
		.i_raddr(i_address[2 +: CODE_AW]),
		.o_rdata(mem_rdata)
	);

	// Pin variant always calibrates manually from the pin
	assign pin_manual = i_trim_pin && (P_PIN_VARIANT || !method_q);

	always_ff @(posedge i_clk)
	begin
		if (!i_resetn)
			o_amp_cal <= '0;
		else
			o_amp_cal <= (method_q ? '0 : req_q) | {NAMP{pin_manual}}
				| (eng_busy ? run_mask_q : '0);
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_resetn)
		begin
			o_amp_gain <= GAIN_RST;
			o_ref_div_bypass <= 1'b0;
			o_autotrim_busy <= 1'b0;
		end
		else
		begin
			o_amp_gain <= eng_busy ? GAIN_40 : gain_q;
			o_ref_div_bypass <= unidir_q && !eng_busy;
			o_autotrim_busy <= eng_busy;
		end
	end

	// Trial codes drive the trimmed amplifiers while the search runs
	always_ff @(posedge i_clk)
	begin
		for (int i = 0; i < NAMP; i++)
		begin
			if (!i_resetn)
				o_amp_trim_code[i*TRIM_W +: TRIM_W] <= CODE_RST;
			else if (eng_busy && run_mask_q[i])
				o_amp_trim_code[i*TRIM_W +: TRIM_W] <=
					eng_code[i*TRIM_W +: TRIM_W];
			else
				o_amp_trim_code[i*TRIM_W +: TRIM_W] <= code_q[i];
		end
	end

	// Helper counter: length of the current trim run
	always_ff @(posedge i_clk)
	begin
		if (!i_resetn || !eng_busy)
			run_cnt_q <= '0;
		else if (run_cnt_q != 16'hFFFF)
			run_cnt_q <= run_cnt_q + 16'h0001;
	end

	chk_bus_answer: assert property (
		@(posedge i_clk) disable iff (!i_resetn)
		(i_read || i_write) && wait_q |-> ##[1:BUS_MAX] !o_waitrequest)
		else $error("Bus request not answered in time");

	chk_gain_prog: assert property (
		@(posedge i_clk) disable iff (!i_resetn)
		!eng_busy |=> o_amp_gain == $past(gain_q))
		else $error("Programmed gain not applied");

	chk_bypass_set: assert property (
		@(posedge i_clk) disable iff (!i_resetn)
		!eng_busy && unidir_q |=> o_ref_div_bypass)
		else $error("Divider bypass not applied");

	chk_req_only: assert property (
		@(posedge i_clk) disable iff (!i_resetn)
		!eng_busy && !i_trim_pin && !method_q
			|=> o_amp_cal == $past(req_q))
		else $error("Calibration not limited to requested amplifier");

	chk_req_queued: assert property (
		@(posedge i_clk) disable iff (!i_resetn)
		req_wr && method_q && rtauto_q && eng_busy
			|=> (pend_q & $past(req_new)) == $past(req_new))
		else $error("Trim request lost while busy");

	chk_pin_all: assert property (
		@(posedge i_clk) disable iff (!i_resetn)
		i_trim_pin && (!method_q || P_PIN_VARIANT) |=> o_amp_cal == ALL_AMPS)
		else $error("Trim pin did not short all amplifiers");

	chk_pwr_start: assert property (
		@(posedge i_clk) disable iff (!i_resetn)
		i_vref_ok && !vref_prev_q && !pwr_done_q && !eng_busy
			|-> ##[1:SETTLE_MAX] eng_busy)
		else $error("Power-up trim did not start");

	chk_trim_bound: assert property (
		@(posedge i_clk) disable iff (!i_resetn)
		32'(run_cnt_q) <= P_AUTO_MAX_CYC)
		else $error("Automatic trim exceeded its time");

	chk_code_store: assert property (
		@(posedge i_clk) disable iff (!i_resetn)
		eng_done && run_mask_q == ALL_AMPS && pend_q == '0
			|-> ##2 o_amp_trim_code == $past(eng_code, 2))
		else $error("Trim codes not stored");

	chk_bidir_trim: assert property (
		@(posedge i_clk) disable iff (!i_resetn)
		eng_busy |=> !o_ref_div_bypass)
		else $error("Bypass active during trim");

	chk_gain_trim: assert property (
		@(posedge i_clk) disable iff (!i_resetn)
		eng_busy ##1 !eng_busy |-> o_amp_gain == GAIN_40
			##1 o_amp_gain == $past(gain_q))
		else $error("Gain not forced or restored around trim");

	chk_pin_variant: assert property (
		@(posedge i_clk) disable iff (!i_resetn)
		P_PIN_VARIANT |=> req_q == '0)
		else $error("Request bits present on pin variant");

	chk_release: assert property (
		@(posedge i_clk) disable iff (!i_resetn)
		$fell(i_trim_pin) && req_q == '0 && !eng_busy |=> o_amp_cal == '0)
		else $error("Shunts not reconnected after release");
endmodule

// *** bench/csacal_host_model.sv ***
`timescale 1ns/100ps
module csacal_host_model
#(
	parameter logic [2:0] P_KEEP = 3'h5,
	parameter int P_WAIT = 40
)
(
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic i_busy,
	input wire logic [2:0] i_cal,
	input wire logic i_pin_cmd,
	output logic o_trim_pin,
	output logic [2:0] o_amp_cmp,
	output logic o_ready
);
	logic [2:0] noise_q;
	int wait_q;
	// pin moves only on host command
	always_ff @(posedge i_clk)
	begin
		if (!i_resetn)
			o_trim_pin <= 1'b0;
		else
			o_trim_pin <= i_pin_cmd;
	end
	// Outside a trim the comparator moves every cycle, so stale data shows
	always_ff @(posedge i_clk)
	begin
		if (!i_resetn)
			noise_q <= 3'h2;
		else
			noise_q <= ~noise_q;
	end
	assign o_amp_cmp = i_busy ? P_KEEP : noise_q;
	always_ff @(posedge i_clk)
	begin
		if (!i_resetn || i_cal == 3'h0)
			wait_q <= 0;
		else if (wait_q < P_WAIT)
			wait_q <= wait_q + 1;
	end
	assign o_ready = (wait_q >= P_WAIT);
endmodule

// *** bench/testbench.sv ***
`timescale 1ns/100ps
module testbench;
	import csacal_pkg::*;
	localparam logic [2:0] KEEP = 3'h5;
	logic i_clk, i_resetn, i_read, i_write, i_vref_ok, pin_cmd, trim_pin;
	logic host_ready, o_waitrequest, o_ref_div_bypass, o_autotrim_busy;
	logic [ADDR_W-1:0] i_address;
	logic [31:0] i_writedata, o_readdata, rd;
	logic [3:0] i_byteenable;
	logic [1:0] o_amp_gain;
	logic [NAMP-1:0] amp_cmp, o_amp_cal;
	logic [NAMP*TRIM_W-1:0] o_amp_trim_code, exp_code;
	logic [NAMP-1:0] pv_cal;
	logic pv_busy;
	int bad_count, n_compared, n, t;
	csacal_top #(.P_PIN_VARIANT(1'b0), .P_AUTO_MAX_CYC(40), .P_STEP_CYC(4))
	dut_u (.i_clk(i_clk), .i_resetn(i_resetn), .i_address(i_address),
		.i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
		.i_byteenable(i_byteenable), .o_readdata(o_readdata),
		.o_waitrequest(o_waitrequest), .i_vref_ok(i_vref_ok),
		.i_trim_pin(trim_pin), .i_amp_cmp(amp_cmp), .o_amp_gain(o_amp_gain),
		.o_ref_div_bypass(o_ref_div_bypass), .o_amp_cal(o_amp_cal),
		.o_amp_trim_code(o_amp_trim_code), .o_autotrim_busy(o_autotrim_busy));
	csacal_host_model #(.P_KEEP(KEEP), .P_WAIT(40))
	host_u (.i_clk(i_clk), .i_resetn(i_resetn), .i_busy(o_autotrim_busy),
		.i_cal(o_amp_cal), .i_pin_cmd(pin_cmd), .o_trim_pin(trim_pin),
		.o_amp_cmp(amp_cmp), .o_ready(host_ready));
	// Pin-strapped variant shares the stimulus of the register variant
	csacal_top #(.P_PIN_VARIANT(1'b1), .P_AUTO_MAX_CYC(40), .P_STEP_CYC(4))
	pv_u (.i_clk(i_clk), .i_resetn(i_resetn), .i_address(i_address),
		.i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
		.i_byteenable(i_byteenable), .o_readdata(), .o_waitrequest(),
		.i_vref_ok(i_vref_ok), .i_trim_pin(trim_pin), .i_amp_cmp(amp_cmp),
		.o_amp_gain(), .o_ref_div_bypass(), .o_amp_cal(pv_cal),
		.o_amp_trim_code(), .o_autotrim_busy(pv_busy));
	task automatic complete_run();
		$display("compared %0d, wrong %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_compared++;
		if (g !== e)
		begin
			$display("wrong value %s expected %h seen %h", nm, e, g);
			bad_count++;
		end
	endtask
	task automatic bus(input logic w, input logic [ADDR_W-1:0] a,
		input logic [31:0] d, input logic [3:0] be);
		int k;
		@(posedge i_clk);
		i_address <= a;
		i_writedata <= d;
		i_byteenable <= be;
		i_write <= w;
		i_read <= ~w;
		k = 0;
		do
		begin
			@(posedge i_clk);
			k++;
		end
		while (o_waitrequest !== 1'b0);
		rd = o_readdata;
		i_read <= 1'b0;
		i_write <= 1'b0;
		chk("bus wait", 32'd3, 32'(k));
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 4'hF);
	endtask
	task automatic rdchk(input string nm, input logic [ADDR_W-1:0] a,
		input logic [31:0] e);
		bus(1'b0, a, 32'h0, 4'hF);
		chk(nm, e, rd);
	endtask
	task automatic settle();
		repeat (3) @(posedge i_clk);
	endtask
	// Counts cycles in n until busy reaches lvl, bounded
	task automatic wait_busy(input logic lvl);
		n = 0;
		while (o_autotrim_busy !== lvl && n < 200)
		begin
			@(posedge i_clk);
			n++;
		end
		chk("busy wait", 1, n < 200);
	endtask
	initial
	begin
		i_clk = 1'b0;
		forever #2 i_clk = ~i_clk;
	end
	initial
	begin
		#80000;
		bad_count++;
		complete_run();
	end
	initial
	begin
		{i_read, i_write, i_vref_ok, pin_cmd, i_resetn} = 5'h0;
		i_address = '0;
		i_writedata = 32'h0;
		i_byteenable = 4'hF;
		bad_count = 0;
		n_compared = 0;
		for (int i = 0; i < NAMP; i++)
			exp_code[i*TRIM_W +: TRIM_W] = KEEP[i] ? 6'h3F : 6'h00;
		repeat (3) @(posedge i_clk);
		i_resetn <= 1'b1;
		rdchk("ctrl reset", OFS_CTRL, 32'h0);
		rdchk("code reset", OFS_CODE, {26'h0, CODE_RST});
		rdchk("unmapped", 6'h3C, 32'h0);
		wr(OFS_CTRL, 32'h05);
		bus(1'b1, OFS_CTRL, 32'h02, 4'h0);
		settle();
		chk("gain", 32'h1, {30'h0, o_amp_gain});
		chk("bypass", 32'h1, {31'h0, o_ref_div_bypass});
		i_vref_ok <= 1'b1;
		wait_busy(1'b1);
		t = n;
		repeat (2) @(posedge i_clk);
		chk("forced gain", GAIN_40, {30'h0, o_amp_gain});
		chk("forced bidir", 32'h0, {31'h0, o_ref_div_bypass});
		chk("auto cal", 32'h7, {29'h0, o_amp_cal});
		wait_busy(1'b0);
		chk("trim time", 1, t + n + 2 <= 40);
		settle();
		chk("codes", {14'h0, exp_code}, {14'h0, o_amp_trim_code});
		chk("gain back", 32'h1, {30'h0, o_amp_gain});
		chk("unidir back", 32'h1, {31'h0, o_ref_div_bypass});
		chk("cal off", 32'h0, {29'h0, o_amp_cal});
		for (int i = 0; i < NAMP; i++)
			rdchk("code reg", OFS_CODE + 6'(4 * i),
				{26'h0, exp_code[i*TRIM_W +: TRIM_W]});
		for (int g = 0; g < 4; g++)
		begin
			wr(OFS_CTRL, 32'(g));
			settle();
			chk("gain sel", 32'(g), {30'h0, o_amp_gain});
		end
		for (int i = 0; i < NAMP; i++)
		begin
			wr(OFS_REQ, 32'(1 << i));
			settle();
			chk("one amp cal", 32'(1 << i), {29'h0, o_amp_cal});
			chk("pin variant req", 32'h0, {29'h0, pv_cal});
			rdchk("status", OFS_STAT, 32'h10 | 32'(1 << i));
			n = 0;
			while (host_ready !== 1'b1 && n < 100)
			begin
				@(posedge i_clk);
				n++;
			end
			chk("host wait", 1, n < 100);
			wr(OFS_REQ, 32'h0);
			settle();
			chk("cal release", 32'h0, {29'h0, o_amp_cal});
		end
		pin_cmd <= 1'b1;
		repeat (4) @(posedge i_clk);
		chk("pin cal", 32'h7, {29'h0, o_amp_cal});
		pin_cmd <= 1'b0;
		repeat (4) @(posedge i_clk);
		chk("pin release", 32'h0, {29'h0, o_amp_cal});
		wr(OFS_CTRL, 32'h08);
		wr(OFS_REQ, 32'h2);
		n = 0;
		repeat (10)
		begin
			@(posedge i_clk);
			if (o_autotrim_busy !== 1'b0)
				n++;
		end
		chk("no trim", 32'h0, 32'(n));
		chk("no manual", 32'h0, {29'h0, o_amp_cal});
		wr(OFS_CTRL, 32'h19);
		wr(OFS_REQ, 32'h0);
		wr(OFS_REQ, 32'h1);
		wait_busy(1'b1);
		repeat (2) @(posedge i_clk);
		chk("rt gain", GAIN_40, {30'h0, o_amp_gain});
		wait_busy(1'b0);
		settle();
		chk("rt gain back", 32'h1, {30'h0, o_amp_gain});
		rdchk("req clear", OFS_REQ, 32'h0);
		pin_cmd <= 1'b1;
		wait_busy(1'b1);
		chk("pin variant cal", 32'h7, {29'h0, pv_cal});
		chk("pin variant auto", 32'h0, {31'h0, pv_busy});
		pin_cmd <= 1'b0;
		wr(OFS_REQ, 32'h4);
		wait_busy(1'b0);
		wait_busy(1'b1);
		wait_busy(1'b0);
		settle();
		chk("final cal", 32'h0, {29'h0, o_amp_cal});
		complete_run();
	end
endmodule
